// ### logic/ptw_timer.sv
// ptw_timer: enhanced 64/2x32-bit timer with capture, reload and watchdog
`timescale 1ns/100ps
`default_nettype none

module ptw_timer
   import ptw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire ptw_bus_req_t bus_req,
   output logic [31:0] bus_rdata,
   // external count / capture pin
   input wire logic external_count_input,
   // events
   output logic irq,
   output ptw_evt_t dma_sync,
   output logic realtime_output_trigger,
   output logic reset_request
);

   function automatic ptw_edge_t ptw_edge_sel(input logic [1:0] code);
      return ptw_edge_t'(code);
   endfunction

   // next value of one 32-bit half
   function automatic logic [31:0] ptw_half_next(input logic [31:0] cnt,
                                                input logic tick,
                                                input logic done);
      logic [31:0] res;
      res = cnt;
      if (tick)
      begin
         res = done ? 32'h0000_0000 : cnt + 32'h0000_0001;
      end
      return res;
   endfunction

   logic [PTW_TC_W-1:0] tc_reg;
   logic [PTW_GC_W-1:0] gc_reg;
   logic [31:0] emu_reg;
   logic [31:0] cnt_lo_reg;
   logic [31:0] cnt_hi_reg;
   logic [31:0] prd_lo_reg;
   logic [31:0] prd_hi_reg;
   logic [31:0] rel_lo_reg;
   logic [31:0] rel_hi_reg;
   logic [31:0] cap_lo_reg;
   logic [31:0] cap_hi_reg;
   logic [PTW_IS_W-1:0] ists_reg;
   logic [PTW_IS_W-1:0] ists_next;
   logic [PTW_IS_W-1:0] imask_reg;
   logic wd_en_reg;
   logic wd_flag_reg;
   ptw_key_t key_reg;
   logic [31:0] rdata_reg;
   ptw_evt_t dma_reg;
   logic rto_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic sync3_reg;

   // decode
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_prd_lo;
   logic wr_prd_hi;
   logic wr_tc;
   logic wr_gc;
   logic wr_wd;
   logic rd_cnt_lo;
   logic rd_cnt_hi;
   logic rd_ists;

   assign wr_cnt_lo = bus_req.wr && bus_req.addr == PTW_OFS_CNT_LO && !wd_en_reg;
   assign wr_cnt_hi = bus_req.wr && bus_req.addr == PTW_OFS_CNT_HI && !wd_en_reg;
   assign wr_prd_lo = bus_req.wr && bus_req.addr == PTW_OFS_PRD_LO;
   assign wr_prd_hi = bus_req.wr && bus_req.addr == PTW_OFS_PRD_HI;
   assign wr_tc = bus_req.wr && bus_req.addr == PTW_OFS_TCTL && !wd_en_reg;
   assign wr_gc = bus_req.wr && bus_req.addr == PTW_OFS_GCTL && !wd_en_reg;
   assign wr_wd = bus_req.wr && bus_req.addr == PTW_OFS_WDCTL;
   assign rd_cnt_lo = bus_req.rd && bus_req.addr == PTW_OFS_CNT_LO;
   assign rd_cnt_hi = bus_req.rd && bus_req.addr == PTW_OFS_CNT_HI;
   assign rd_ists = bus_req.rd && bus_req.addr == PTW_OFS_ISTAT;

   // configuration, forced to a free-running 64-bit count under watchdog
   ptw_run_t mode_lo;
   ptw_run_t mode_hi;
   ptw_size_t size;
   logic run_lo;
   logic run_hi;
   logic ext_lo;
   logic ext_hi;
   logic wide;
   logic chained;

   assign mode_lo = wd_en_reg ? PTW_RUN_CONT : ptw_run_t'(tc_reg[PTW_TC_MODE_LO +: 2]);
   assign mode_hi = wd_en_reg ? PTW_RUN_CONT : ptw_run_t'(tc_reg[PTW_TC_MODE_HI +: 2]);
   assign size = wd_en_reg ? PTW_SZ_64 : ptw_size_t'(gc_reg[PTW_GC_SIZE +: 2]);
   assign run_lo = wd_en_reg || gc_reg[PTW_GC_RUN_LO];
   assign run_hi = wd_en_reg || gc_reg[PTW_GC_RUN_HI];
   assign ext_lo = !wd_en_reg && tc_reg[PTW_TC_EXT_LO];
   assign ext_hi = !wd_en_reg && tc_reg[PTW_TC_EXT_HI];
   // reserved size code behaves as 64-bit
   assign wide = size == PTW_SZ_64 || size == PTW_SZ_RSVD;
   assign chained = size == PTW_SZ_CHAINED;

   // pin synchroniser; third stage only feeds the edge detector
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= external_count_input;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   logic ext_edge;

   always_comb
   begin
      case (ptw_edge_sel(tc_reg[PTW_TC_EDGE +: 2]))
         PTW_EDGE_RISE: ext_edge = sync2_reg && !sync3_reg;
         PTW_EDGE_FALL: ext_edge = !sync2_reg && sync3_reg;
         PTW_EDGE_BOTH: ext_edge = sync2_reg != sync3_reg;
         default: ext_edge = 1'b0;
      endcase
   end

   // ticks and period completion
   logic act_lo;
   logic act_hi;
   logic tick_lo;
   logic tick_hi;
   logic done_lo;
   logic done_hi;
   logic done64;
   logic evt_lo;
   logic evt_hi;

   assign act_lo = run_lo && mode_lo != PTW_RUN_OFF;
   assign act_hi = run_hi && mode_hi != PTW_RUN_OFF;
   assign tick_lo = act_lo && (ext_lo ? ext_edge : 1'b1);
   assign done64 = tick_lo && {cnt_hi_reg, cnt_lo_reg} == {prd_hi_reg, prd_lo_reg};
   assign done_lo = tick_lo && cnt_lo_reg == prd_lo_reg;
   // chained: low half acts as prescaler for high half
   assign tick_hi = chained ? (done_lo && act_hi)
                            : (act_hi && (ext_hi ? ext_edge : 1'b1));
   assign done_hi = tick_hi && cnt_hi_reg == prd_hi_reg;
   assign evt_lo = wide ? done64 : done_lo;
   assign evt_hi = wide ? 1'b0 : done_hi;

   // counters
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_lo_reg <= PTW_ZERO_RST;
         cnt_hi_reg <= PTW_ZERO_RST;
      end
      else if (wd_en_reg && wr_wd && key_reg == PTW_KEY_ARMED
               && bus_req.wdata[PTW_WD_KEY +: 16] == PTW_WD_KEY_SECOND)
      begin
         cnt_lo_reg <= PTW_ZERO_RST;
         cnt_hi_reg <= PTW_ZERO_RST;
      end
      else if (wide)
      begin
         if (!run_lo || (rd_cnt_lo && tc_reg[PTW_TC_RDRST_LO]))
         begin
            cnt_lo_reg <= PTW_ZERO_RST;
         end
         else if (wr_cnt_lo)
         begin
            cnt_lo_reg <= bus_req.wdata;
         end
         else if (tick_lo)
         begin
            cnt_lo_reg <= done64 ? PTW_ZERO_RST : cnt_lo_reg + 32'h0000_0001;
         end
         if (!run_lo || (rd_cnt_hi && tc_reg[PTW_TC_RDRST_HI]))
         begin
            cnt_hi_reg <= PTW_ZERO_RST;
         end
         else if (wr_cnt_hi)
         begin
            cnt_hi_reg <= bus_req.wdata;
         end
         else if (tick_lo)
         begin
            cnt_hi_reg <= done64 ? PTW_ZERO_RST
                                 : cnt_hi_reg + {31'h0, &cnt_lo_reg};
         end
      end
      else
      begin
         if (!run_lo || (rd_cnt_lo && tc_reg[PTW_TC_RDRST_LO]))
         begin
            cnt_lo_reg <= PTW_ZERO_RST;
         end
         else if (wr_cnt_lo)
         begin
            cnt_lo_reg <= bus_req.wdata;
         end
         else
         begin
            cnt_lo_reg <= ptw_half_next(cnt_lo_reg, tick_lo, done_lo);
         end
         if (!run_hi || (rd_cnt_hi && tc_reg[PTW_TC_RDRST_HI]))
         begin
            cnt_hi_reg <= PTW_ZERO_RST;
         end
         else if (wr_cnt_hi)
         begin
            cnt_hi_reg <= bus_req.wdata;
         end
         else
         begin
            cnt_hi_reg <= ptw_half_next(cnt_hi_reg, tick_hi, done_hi);
         end
      end
   end

   // control; one-time mode drops back to off when its period ends
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         tc_reg <= '0;
         gc_reg <= '0;
         emu_reg <= PTW_ZERO_RST;
         imask_reg <= '0;
      end
      else
      begin
         if (wr_tc)
         begin
            tc_reg <= bus_req.wdata[PTW_TC_W-1:0];
         end
         else
         begin
            if (evt_lo && mode_lo == PTW_RUN_ONCE)
            begin
               tc_reg[PTW_TC_MODE_LO +: 2] <= PTW_RUN_OFF;
            end
            if (evt_hi && mode_hi == PTW_RUN_ONCE)
            begin
               tc_reg[PTW_TC_MODE_HI +: 2] <= PTW_RUN_OFF;
            end
         end
         if (wr_gc)
         begin
            gc_reg <= bus_req.wdata[PTW_GC_W-1:0];
         end
         if (bus_req.wr && bus_req.addr == PTW_OFS_EMU)
         begin
            emu_reg <= bus_req.wdata;
         end
         if (bus_req.wr && bus_req.addr == PTW_OFS_IMASK)
         begin
            imask_reg <= bus_req.wdata[PTW_IS_W-1:0];
         end
      end
   end

   // period and reload registers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         prd_lo_reg <= PTW_PRD_RST;
         prd_hi_reg <= PTW_PRD_RST;
         rel_lo_reg <= PTW_PRD_RST;
         rel_hi_reg <= PTW_PRD_RST;
      end
      else
      begin
         if (wr_prd_lo)
         begin
            prd_lo_reg <= bus_req.wdata;
         end
         else if (evt_lo && mode_lo == PTW_RUN_RELOAD)
         begin
            prd_lo_reg <= rel_lo_reg;
         end
         if (wr_prd_hi)
         begin
            prd_hi_reg <= bus_req.wdata;
         end
         else if ((wide ? evt_lo && mode_lo == PTW_RUN_RELOAD
                        : evt_hi && mode_hi == PTW_RUN_RELOAD))
         begin
            prd_hi_reg <= rel_hi_reg;
         end
         if (bus_req.wr && bus_req.addr == PTW_OFS_REL_LO)
         begin
            rel_lo_reg <= bus_req.wdata;
         end
         if (bus_req.wr && bus_req.addr == PTW_OFS_REL_HI)
         begin
            rel_hi_reg <= bus_req.wdata;
         end
      end
   end

   // capture
   logic cap_lo_hit;
   logic cap_hi_hit;

   assign cap_lo_hit = !wd_en_reg && ext_edge && tc_reg[PTW_TC_CAP_LO];
   assign cap_hi_hit = !wd_en_reg && ext_edge && tc_reg[PTW_TC_CAP_HI];

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cap_lo_reg <= PTW_ZERO_RST;
         cap_hi_reg <= PTW_ZERO_RST;
      end
      else
      begin
         if (cap_lo_hit)
         begin
            cap_lo_reg <= cnt_lo_reg;
         end
         if (cap_hi_hit)
         begin
            cap_hi_reg <= cnt_hi_reg;
         end
      end
   end

   // watchdog: enable is write-once until reset, key pair services it
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wd_en_reg <= 1'b0;
         wd_flag_reg <= 1'b0;
         key_reg <= PTW_KEY_IDLE;
      end
      else
      begin
         if (wr_wd && bus_req.wdata[PTW_WD_EN])
         begin
            wd_en_reg <= 1'b1;
         end
         if (wd_en_reg && done64)
         begin
            wd_flag_reg <= 1'b1;
         end
         if (wr_wd)
         begin
            case (key_reg)
               PTW_KEY_IDLE:
                  key_reg <= (bus_req.wdata[PTW_WD_KEY +: 16] == PTW_WD_KEY_FIRST)
                             ? PTW_KEY_ARMED : PTW_KEY_IDLE;
               PTW_KEY_ARMED:
                  key_reg <= (bus_req.wdata[PTW_WD_KEY +: 16] == PTW_WD_KEY_FIRST)
                             ? PTW_KEY_ARMED : PTW_KEY_IDLE;
               default: key_reg <= PTW_KEY_IDLE;
            endcase
         end
      end
   end

   // interrupt status: a new event wins over clear-on-read
   always_comb
   begin
      ists_next = rd_ists ? '0 : ists_reg;
      ists_next[PTW_IS_PRD_LO] = ists_next[PTW_IS_PRD_LO] | evt_lo;
      ists_next[PTW_IS_PRD_HI] = ists_next[PTW_IS_PRD_HI] | evt_hi;
      ists_next[PTW_IS_CAP_LO] = ists_next[PTW_IS_CAP_LO] | cap_lo_hit;
      ists_next[PTW_IS_CAP_HI] = ists_next[PTW_IS_CAP_HI] | cap_hi_hit;
   end

   // event outputs and status
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ists_reg <= '0;
         dma_reg <= '0;
         rto_reg <= 1'b0;
      end
      else
      begin
         ists_reg <= ists_next;
         dma_reg.lo <= evt_lo;
         dma_reg.hi <= evt_hi;
         rto_reg <= !wd_en_reg && (gc_reg[PTW_GC_RTO_SEL] ? evt_hi : evt_lo);
      end
   end

   // read data, valid the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         rdata_reg <= PTW_ZERO_RST;
      end
      else if (!bus_req.rd)
      begin
         rdata_reg <= PTW_ZERO_RST;
      end
      else
      begin
         case (bus_req.addr)
            PTW_OFS_PID: rdata_reg <= PTW_PID_VALUE;
            PTW_OFS_EMU: rdata_reg <= emu_reg;
            PTW_OFS_CNT_LO: rdata_reg <= cnt_lo_reg;
            PTW_OFS_CNT_HI: rdata_reg <= cnt_hi_reg;
            PTW_OFS_PRD_LO: rdata_reg <= prd_lo_reg;
            PTW_OFS_PRD_HI: rdata_reg <= prd_hi_reg;
            PTW_OFS_TCTL: rdata_reg <= {{(32-PTW_TC_W){1'b0}}, tc_reg};
            PTW_OFS_GCTL: rdata_reg <= {{(32-PTW_GC_W){1'b0}}, gc_reg};
            PTW_OFS_WDCTL: rdata_reg <= {16'h0000, wd_flag_reg, wd_en_reg, 14'h0000};
            PTW_OFS_REL_LO: rdata_reg <= rel_lo_reg;
            PTW_OFS_REL_HI: rdata_reg <= rel_hi_reg;
            PTW_OFS_CAP_LO: rdata_reg <= cap_lo_reg;
            PTW_OFS_CAP_HI: rdata_reg <= cap_hi_reg;
            PTW_OFS_ISTAT: rdata_reg <= {{(32-PTW_IS_W){1'b0}}, ists_reg};
            PTW_OFS_IMASK: rdata_reg <= {{(32-PTW_IS_W){1'b0}}, imask_reg};
            default: rdata_reg <= PTW_ZERO_RST;
         endcase
      end
   end

   assign bus_rdata = rdata_reg;
   assign irq = |(ists_reg & imask_reg);
   assign dma_sync = dma_reg;
   assign realtime_output_trigger = rto_reg;
   assign reset_request = wd_flag_reg;

endmodule // ptw_timer

`default_nettype wire

// ### pkg/ptw_pkg.sv
// ptw_pkg: register map, fields and types of the timer/watchdog block
package ptw_pkg;

   // register offsets (byte addresses)
   localparam logic [7:0] PTW_OFS_PID = 8'h00;
   localparam logic [7:0] PTW_OFS_EMU = 8'h04;
   localparam logic [7:0] PTW_OFS_CNT_LO = 8'h10;
   localparam logic [7:0] PTW_OFS_CNT_HI = 8'h14;
   localparam logic [7:0] PTW_OFS_PRD_LO = 8'h18;
   localparam logic [7:0] PTW_OFS_PRD_HI = 8'h1C;
   localparam logic [7:0] PTW_OFS_TCTL = 8'h20;
   localparam logic [7:0] PTW_OFS_GCTL = 8'h24;
   localparam logic [7:0] PTW_OFS_WDCTL = 8'h28;
   localparam logic [7:0] PTW_OFS_REL_LO = 8'h34;
   localparam logic [7:0] PTW_OFS_REL_HI = 8'h38;
   localparam logic [7:0] PTW_OFS_CAP_LO = 8'h3C;
   localparam logic [7:0] PTW_OFS_CAP_HI = 8'h40;
   localparam logic [7:0] PTW_OFS_ISTAT = 8'h44;
   localparam logic [7:0] PTW_OFS_IMASK = 8'h48;

   // timer_control fields
   localparam int PTW_TC_MODE_LO = 0;
   localparam int PTW_TC_MODE_HI = 2;
   localparam int PTW_TC_EXT_LO = 4;
   localparam int PTW_TC_EXT_HI = 5;
   localparam int PTW_TC_CAP_LO = 6;
   localparam int PTW_TC_CAP_HI = 7;
   localparam int PTW_TC_EDGE = 8;
   localparam int PTW_TC_RDRST_LO = 10;
   localparam int PTW_TC_RDRST_HI = 11;
   localparam int PTW_TC_W = 12;

   // global_control fields
   localparam int PTW_GC_RUN_LO = 0;
   localparam int PTW_GC_RUN_HI = 1;
   localparam int PTW_GC_SIZE = 2;
   localparam int PTW_GC_RTO_SEL = 4;
   localparam int PTW_GC_W = 5;

   // watchdog_control fields
   localparam int PTW_WD_EN = 14;
   localparam int PTW_WD_FLAG = 15;
   localparam int PTW_WD_KEY = 16;
   localparam logic [15:0] PTW_WD_KEY_FIRST = 16'h5A5A;
   localparam logic [15:0] PTW_WD_KEY_SECOND = 16'hA5A5;

   // interrupt status / mask bits
   localparam int PTW_IS_PRD_LO = 0;
   localparam int PTW_IS_PRD_HI = 1;
   localparam int PTW_IS_CAP_LO = 2;
   localparam int PTW_IS_CAP_HI = 3;
   localparam int PTW_IS_W = 4;

   // values after reset; identification value is arbitrary
   localparam logic [31:0] PTW_PID_VALUE = 32'h0001_0100;
   localparam logic [31:0] PTW_PRD_RST = 32'hFFFF_FFFF;
   localparam logic [31:0] PTW_ZERO_RST = 32'h0000_0000;

   typedef enum logic [1:0] {
      PTW_RUN_OFF = 2'b00,
      PTW_RUN_ONCE = 2'b01,
      PTW_RUN_CONT = 2'b10,
      PTW_RUN_RELOAD = 2'b11
   } ptw_run_t;

   typedef enum logic [1:0] {
      PTW_SZ_64 = 2'b00,
      PTW_SZ_UNCHAINED = 2'b01,
      PTW_SZ_RSVD = 2'b10,
      PTW_SZ_CHAINED = 2'b11
   } ptw_size_t;

   typedef enum logic [1:0] {
      PTW_EDGE_RISE = 2'b00,
      PTW_EDGE_FALL = 2'b01,
      PTW_EDGE_BOTH = 2'b10,
      PTW_EDGE_NONE = 2'b11
   } ptw_edge_t;

   typedef enum logic {
      PTW_KEY_IDLE = 1'b0,
      PTW_KEY_ARMED = 1'b1
   } ptw_key_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ptw_bus_req_t;

   typedef struct packed {
      logic hi;
      logic lo;
   } ptw_evt_t;

endpackage

// ### testbench/ptw_timer_chk.sv
// ptw_timer_chk: port-level assertions for the timer block
`timescale 1ns/100ps
`default_nettype none

module ptw_timer_chk
   import ptw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire ptw_bus_req_t bus_req,
   input wire logic [31:0] bus_rdata,
   // pins and events
   input wire logic external_count_input,
   input wire logic irq,
   input wire ptw_evt_t dma_sync,
   input wire logic realtime_output_trigger,
   input wire logic reset_request
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sequence s_pid_rd;
      bus_req.rd && bus_req.addr == PTW_OFS_PID;
   endsequence

   sequence s_flag_rd;
      bus_req.rd && bus_req.addr == PTW_OFS_WDCTL && reset_request;
   endsequence

   a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
      else $error("read data not zero outside a read");
   a_pid_value: assert property (s_pid_rd |=> bus_rdata == PTW_PID_VALUE)
      else $error("identification read wrong");
   a_unmapped_zero: assert property (bus_req.rd && bus_req.addr == 8'h08 |=> bus_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_dma_lo_pulse: assert property (dma_sync.lo |=> !dma_sync.lo)
      else $error("low sync event longer than one cycle");
   a_dma_hi_pulse: assert property (dma_sync.hi |=> !dma_sync.hi)
      else $error("high sync event longer than one cycle");
   a_rto_with_evt: assert property (realtime_output_trigger |-> dma_sync.lo || dma_sync.hi)
      else $error("output trigger without timer event");
   a_rst_req_hold: assert property ($rose(reset_request) |=> reset_request [*4])
      else $error("reset request dropped");
   a_wd_flag_read: assert property (s_flag_rd |=> bus_rdata[PTW_WD_FLAG])
      else $error("expired flag not reported");
endmodule // ptw_timer_chk

bind ptw_timer ptw_timer_chk u_chk (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .bus_req(bus_req),
   .bus_rdata(bus_rdata),
   .external_count_input(external_count_input),
   .irq(irq),
   .dma_sync(dma_sync),
   .realtime_output_trigger(realtime_output_trigger),
   .reset_request(reset_request)
);

`default_nettype wire

// ### testbench/ptw_timer_tb.sv
// ptw_timer_tb: directed register-level tests of the timer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
   begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
         n_mismatch++; \
         $display("[FAIL] %0t: got %h expected %h", $time, (g), (e)); \
      end \
   end

module ptw_timer_tb
   import ptw_pkg::*;
();
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   ptw_bus_req_t bus_req = '0;
   logic external_count_input = 1'b0;
   logic [31:0] bus_rdata;
   logic irq;
   ptw_evt_t dma_sync;
   logic realtime_output_trigger;
   logic reset_request;
   int n_mismatch = 0;
   int checks_done = 0;
   logic [31:0] d;
   int n;
   logic trig;

   always #2 clk_sys = ~clk_sys;

   ptw_timer u_ptw_timer (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .bus_req(bus_req),
      .bus_rdata(bus_rdata),
      .external_count_input(external_count_input),
      .irq(irq),
      .dma_sync(dma_sync),
      .realtime_output_trigger(realtime_output_trigger),
      .reset_request(reset_request)
   );

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.wdata <= v;
      bus_req.wr <= 1'b1;
      @(posedge clk_sys);
      bus_req.wr <= 1'b0;
   endtask

   // data is taken at the edge after the strobe, before that edge's update lands
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge clk_sys);
      bus_req.rd <= 1'b0;
      @(posedge clk_sys);
      v = bus_rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a, d);
      `CHK(d, e)
   endtask

   // returns edges counted from this call to the event; bounded so a dead timer cannot hang
   task automatic wait_evt(input bit hi, output int c);
      c = 0;
      do
      begin
         @(posedge clk_sys);
         c++;
      end
      while ((hi ? dma_sync.hi : dma_sync.lo) !== 1'b1 && c < 300);
      trig = realtime_output_trigger;
      if (c >= 300)
      begin
         n_mismatch++;
         $display("[FAIL] %0t: no timer event", $time);
      end
   endtask

   // slow pin edges so the synchroniser sees every level
   task automatic pin_pulse();
      repeat (4) @(posedge clk_sys);
      external_count_input <= 1'b1;
      repeat (4) @(posedge clk_sys);
      external_count_input <= 1'b0;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      rchk(PTW_OFS_PID, PTW_PID_VALUE);
      rchk(PTW_OFS_PRD_LO, PTW_PRD_RST);
      rchk(PTW_OFS_REL_HI, PTW_PRD_RST);
      rchk(PTW_OFS_CNT_LO, PTW_ZERO_RST);
      rchk(8'h08, 32'h0);
      wr(PTW_OFS_PID, 32'h1234_5678);
      rchk(PTW_OFS_PID, PTW_PID_VALUE);
      wr(PTW_OFS_EMU, 32'hA5);
      rchk(PTW_OFS_EMU, 32'hA5);
      // dual unchained, continuous, trigger from the high half
      wr(PTW_OFS_PRD_LO, 32'h2);
      wr(PTW_OFS_PRD_HI, 32'h4);
      wr(PTW_OFS_IMASK, 32'h1);
      wr(PTW_OFS_TCTL, 32'hA);
      wr(PTW_OFS_GCTL, 32'h17);
      wait_evt(0, n);
      `CHK(irq, 1'b1);
      wait_evt(0, n);
      `CHK(n, 3);
      wait_evt(1, n);
      wait_evt(1, n);
      `CHK(n, 5);
      `CHK(trig, 1'b1);
      wr(PTW_OFS_GCTL, 32'h0);
      rchk(PTW_OFS_ISTAT, 32'h3);
      rchk(PTW_OFS_ISTAT, 32'h0);
      `CHK(irq, 1'b0);
      rchk(PTW_OFS_CNT_LO, 32'h0);
      // one-time with the interrupt masked off
      wr(PTW_OFS_IMASK, 32'h0);
      wr(PTW_OFS_TCTL, 32'h1);
      wr(PTW_OFS_GCTL, 32'h5);
      wait_evt(0, n);
      `CHK(irq, 1'b0);
      n = 0;
      repeat (20)
      begin
         @(posedge clk_sys);
         if (dma_sync.lo === 1'b1)
            n++;
      end
      `CHK(n, 0);
      rchk(PTW_OFS_TCTL, 32'h0);
      wr(PTW_OFS_TCTL, 32'h1);
      wait_evt(0, n);
      // 64-bit: high period zero, so the pair ends at 3
      wr(PTW_OFS_GCTL, 32'h0);
      wr(PTW_OFS_PRD_LO, 32'h3);
      wr(PTW_OFS_PRD_HI, 32'h0);
      wr(PTW_OFS_TCTL, 32'hA);
      wr(PTW_OFS_GCTL, 32'h3);
      wait_evt(0, n);
      wait_evt(0, n);
      `CHK(n, 4);
      `CHK(trig, 1'b1);
      // chained: high half ticks once per low period
      wr(PTW_OFS_GCTL, 32'h0);
      wr(PTW_OFS_PRD_LO, 32'h1);
      wr(PTW_OFS_PRD_HI, 32'h2);
      wr(PTW_OFS_GCTL, 32'hF);
      wait_evt(1, n);
      wait_evt(1, n);
      `CHK(n, 6);
      // reload takes effect from the second period on
      wr(PTW_OFS_GCTL, 32'h0);
      wr(PTW_OFS_PRD_LO, 32'h2);
      wr(PTW_OFS_REL_LO, 32'h4);
      wr(PTW_OFS_TCTL, 32'h3);
      wr(PTW_OFS_GCTL, 32'h5);
      wait_evt(0, n);
      wait_evt(0, n);
      `CHK(n, 5);
      rchk(PTW_OFS_PRD_LO, 32'h4);
      // external rising edges: count, capture, read-reset
      wr(PTW_OFS_GCTL, 32'h0);
      wr(PTW_OFS_PRD_LO, 32'h64);
      wr(PTW_OFS_TCTL, 32'h452);
      wr(PTW_OFS_GCTL, 32'h5);
      repeat (3) pin_pulse();
      repeat (6) @(posedge clk_sys);
      rchk(PTW_OFS_CNT_LO, 32'h3);
      rchk(PTW_OFS_CNT_LO, 32'h0);
      rd(PTW_OFS_CAP_LO, d);
      `CHK(d, 32'h2);
      rd(PTW_OFS_ISTAT, d);
      `CHK(d[PTW_IS_CAP_LO], 1'b1);
      // watchdog: serviced, locked, then left to expire
      wr(PTW_OFS_GCTL, 32'h0);
      wr(PTW_OFS_TCTL, 32'h0);
      wr(PTW_OFS_PRD_LO, 32'h28);
      wr(PTW_OFS_PRD_HI, 32'h0);
      wr(PTW_OFS_WDCTL, 32'h4000);
      repeat (5)
      begin
         repeat (15) @(posedge clk_sys);
         wr(PTW_OFS_WDCTL, {PTW_WD_KEY_FIRST, 16'h4000});
         wr(PTW_OFS_WDCTL, {PTW_WD_KEY_SECOND, 16'h4000});
      end
      `CHK(reset_request, 1'b0);
      wr(PTW_OFS_TCTL, 32'h2);
      rchk(PTW_OFS_TCTL, 32'h0);
      n = 0;
      while (reset_request !== 1'b1 && n < 100)
      begin
         @(posedge clk_sys);
         n++;
      end
      `CHK(reset_request, 1'b1);
      rd(PTW_OFS_WDCTL, d);
      `CHK(d[PTW_WD_FLAG], 1'b1);
      nrst <= 1'b0;
      @(posedge clk_sys);
      `CHK(reset_request, 1'b0);
      wrap_up();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      $display("[FAIL] %0t: timeout", $time);
      wrap_up();
   end
endmodule // ptw_timer_tb

`default_nettype wire
